/* File: core/hcc_regs.svh */
/*
  Offsets, field positions, reset values and the storage unlock key
  for the host command registers.
  Assumes inclusion by bare name from core design files.
*/
// Behaviour
// - Bit 31 write one copies shadow into storage
// - Bit 30 write one reloads shadow from storage
// - Bit 29 write one clears all latched faults
// - Bit 28 write one clears lock retry counts
// - Bits 27-20 carry key unlocking storage writes
// - Heartbeat flag returns to zero automatically
// - Bits 30-16 hold 15-bit digital speed command
// - Bit 15 selects pin or register speed
// - Both registers reset to all zeros
// - Pin speed reported in 15-bit status field
`ifndef HCC_REGS_SVH
`define HCC_REGS_SVH

// ============================================================
// Register map
`define HCC_ALGO_CMD_OFS 8'hE6
`define HCC_SPEED_CTL_OFS 8'hE8
`define HCC_RESET_VALUE 32'h00000000

// ============================================================
// Fields
`define HCC_STORE_BIT 31
`define HCC_RELOAD_BIT 30
`define HCC_CLRFLT_BIT 29
`define HCC_CLRRETRY_BIT 28
`define HCC_KEY_MSB 27
`define HCC_KEY_LSB 20
`define HCC_HEARTBEAT_BIT 0
`define HCC_SPEED_MSB 30
`define HCC_SPEED_LSB 16
`define HCC_SRC_BIT 15
`define HCC_STATUS_SPEED_MSB 15
`define HCC_STATUS_SPEED_LSB 1

// ============================================================
// Storage unlock key (arbitrary value)
`define HCC_UNLOCK_KEY 8'hA5

`endif

/* File: core/hcc_pkg.sv */
/*
  Types for the host command registers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hcc_pkg;
  typedef logic [14:0] hcc_speed_t;

  typedef struct packed {
    logic store;
    logic reload;
    logic clr_faults;
    logic clr_retry;
    logic heartbeat;
  } hcc_pulses_t;
endpackage

/* File: core/hcc_cmd_if.sv */
/*
  Carries decoded algorithm command writes from the register bank to
  the pulse generator and its outputs back.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface hcc_cmd_if;
  import hcc_pkg::*;
  logic wr;
  logic [31:0] data;
  hcc_pulses_t pulses;
  logic key_bad;
  modport bank (output wr, output data, input pulses, input key_bad);
  modport gen (input wr, input data, output pulses, output key_bad);
endinterface

/* File: core/hcc_pulse_gen.sv */
/*
  Turns an algorithm command write into one-cycle trigger pulses.
  Assumes wr is a single-cycle strobe in the clk domain.
*/
`timescale 1ns/1ps
`include "hcc_regs.svh"
module hcc_pulse_gen
  import hcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Command side
  hcc_cmd_if.gen cmd
);
  typedef struct packed {
    hcc_pulses_t pulses;
    logic key_bad;
  } hcc_gen_state_t;

  hcc_gen_state_t state_reg;
  hcc_gen_state_t state_next;
  logic key_ok;

  // ============================================================
  // Decode
  always_comb begin
    key_ok = cmd.data[`HCC_KEY_MSB:`HCC_KEY_LSB] == `HCC_UNLOCK_KEY;
    state_next = '0;
    if (cmd.wr) begin
      // Only ones act; zeros leave pulses low
      state_next.pulses.store = cmd.data[`HCC_STORE_BIT] & key_ok;
      state_next.key_bad = cmd.data[`HCC_STORE_BIT] & ~key_ok;
      state_next.pulses.reload = cmd.data[`HCC_RELOAD_BIT];
      state_next.pulses.clr_faults = cmd.data[`HCC_CLRFLT_BIT];
      state_next.pulses.clr_retry = cmd.data[`HCC_CLRRETRY_BIT];
      state_next.pulses.heartbeat = cmd.data[`HCC_HEARTBEAT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cmd.pulses = state_reg.pulses;
  assign cmd.key_bad = state_reg.key_bad;

  // ============================================================
  // Checks
  store_key_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmd.wr && cmd.data[`HCC_STORE_BIT] &&
    cmd.data[`HCC_KEY_MSB:`HCC_KEY_LSB] != `HCC_UNLOCK_KEY
    |=> !cmd.pulses.store && cmd.key_bad)
    else $error("Store accepted with wrong key");
  store_fire_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmd.wr && cmd.data[`HCC_STORE_BIT] &&
    cmd.data[`HCC_KEY_MSB:`HCC_KEY_LSB] == `HCC_UNLOCK_KEY
    |=> cmd.pulses.store)
    else $error("Store not issued with right key");
endmodule

/* File: core/hcc_regs_top.sv */
/*
  Host command register bank: algorithm command and speed control.
  Assumes a single-cycle register port on clk from the serial bus
  target, writes and reads one cycle strobes, address in bytes.
*/
`timescale 1ns/1ps
`include "hcc_regs.svh"
module hcc_regs_top
  import hcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Speed inputs
  input wire logic [14:0] pin_speed,
  // Command outputs to the core
  output logic store_config_trigger,
  output logic reload_config_trigger,
  output logic clear_faults_trigger,
  output logic clear_retry_counts_trigger,
  output logic store_key_reject,
  output logic host_heartbeat_flag,
  // Speed to the core
  output logic [14:0] speed_command,
  output logic speed_source_select,
  output logic [14:0] pin_speed_status
);
  typedef struct packed {
    logic [31:0] rdata;
    logic rvalid;
    hcc_speed_t digital_speed;
    logic src_sel;
    hcc_speed_t speed_cmd;
    hcc_speed_t pin_status;
  } hcc_top_state_t;

  hcc_top_state_t state_reg;
  hcc_top_state_t state_next;
  hcc_cmd_if cmd_bus();

  // ============================================================
  // Command decode
  assign cmd_bus.wr = reg_wr && reg_addr == `HCC_ALGO_CMD_OFS;
  assign cmd_bus.data = reg_wdata;

  hcc_pulse_gen u_pulse (
    .clk(clk),
    .sys_rst(sys_rst),
    .cmd(cmd_bus)
  );

  // ============================================================
  // Register bank
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = reg_rd;
    state_next.rdata = 32'h00000000;
    if (reg_wr && reg_addr == `HCC_SPEED_CTL_OFS) begin
      state_next.digital_speed =
        reg_wdata[`HCC_SPEED_MSB:`HCC_SPEED_LSB];
      state_next.src_sel = reg_wdata[`HCC_SRC_BIT];
    end
    // Speed picked by the registered select, one cycle after a write lands
    state_next.speed_cmd = state_reg.src_sel ?
      state_reg.digital_speed : pin_speed;
    state_next.pin_status = pin_speed;
    if (reg_rd) begin
      // Algorithm command is write only and reads zero
      if (reg_addr == `HCC_SPEED_CTL_OFS) begin
        state_next.rdata[`HCC_SPEED_MSB:`HCC_SPEED_LSB] =
          state_reg.digital_speed;
        state_next.rdata[`HCC_SRC_BIT] = state_reg.src_sel;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ============================================================
  // Outputs
  assign reg_rdata = state_reg.rdata;
  assign reg_rvalid = state_reg.rvalid;
  assign store_config_trigger = cmd_bus.pulses.store;
  assign reload_config_trigger = cmd_bus.pulses.reload;
  assign clear_faults_trigger = cmd_bus.pulses.clr_faults;
  assign clear_retry_counts_trigger = cmd_bus.pulses.clr_retry;
  assign store_key_reject = cmd_bus.key_bad;
  // Heartbeat comes from the pulse generator, so it lines up with the
  // other triggers of the same write and falls back by itself
  assign host_heartbeat_flag = cmd_bus.pulses.heartbeat;
  assign speed_command = state_reg.speed_cmd;
  assign speed_source_select = state_reg.src_sel;
  assign pin_speed_status = state_reg.pin_status;

  // ============================================================
  // Checks
  // Strobes as the properties see them, named once to keep lines short
  logic algo_wr_seen;
  logic speed_wr_seen;
  logic speed_rd_seen;
  assign algo_wr_seen = reg_wr && reg_addr == `HCC_ALGO_CMD_OFS;
  assign speed_wr_seen = reg_wr && reg_addr == `HCC_SPEED_CTL_OFS;
  assign speed_rd_seen = reg_rd && reg_addr == `HCC_SPEED_CTL_OFS;

  // ============================================================
  // Trigger checks

  // A lone write gives a pulse of exactly one cycle
  reload_pulse_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    algo_wr_seen && reg_wdata[`HCC_RELOAD_BIT] ##1 !algo_wr_seen
    |-> reload_config_trigger ##1 !reload_config_trigger)
    else $error("Reload pulse wrong");

  // Fault clear follows the write by one cycle
  clear_fault_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    algo_wr_seen && reg_wdata[`HCC_CLRFLT_BIT] |=> clear_faults_trigger)
    else $error("Fault clear missing");

  // Retry count clear follows the write by one cycle
  clear_retry_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    algo_wr_seen && reg_wdata[`HCC_CLRRETRY_BIT]
    |=> clear_retry_counts_trigger)
    else $error("Retry clear missing");

  // No write, no trigger of any kind in the next cycle
  zero_noop_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    !algo_wr_seen
    |=> !reload_config_trigger && !clear_faults_trigger
        && !store_config_trigger && !clear_retry_counts_trigger
        && !store_key_reject && !host_heartbeat_flag)
    else $error("Trigger without write");

  // A zero in the store bit never stores and never rejects
  store_zero_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    algo_wr_seen && !reg_wdata[`HCC_STORE_BIT]
    |=> !store_config_trigger && !store_key_reject)
    else $error("Store acted on zero");

  // A zero in the reload bit does nothing
  reload_zero_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    algo_wr_seen && !reg_wdata[`HCC_RELOAD_BIT]
    |=> !reload_config_trigger)
    else $error("Reload acted on zero");

  // A zero in the fault clear bit does nothing
  fault_zero_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    algo_wr_seen && !reg_wdata[`HCC_CLRFLT_BIT]
    |=> !clear_faults_trigger)
    else $error("Fault clear acted on zero");

  // A zero in the retry clear bit does nothing
  retry_zero_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    algo_wr_seen && !reg_wdata[`HCC_CLRRETRY_BIT]
    |=> !clear_retry_counts_trigger)
    else $error("Retry clear acted on zero");

  // Store and reject are two outcomes of one request, never both
  store_excl_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    !(store_config_trigger && store_key_reject))
    else $error("Store and reject together");

  // A reject always traces back to a store request
  reject_cause_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    store_key_reject
    |-> $past(algo_wr_seen && reg_wdata[`HCC_STORE_BIT]))
    else $error("Reject without store request");

  // ============================================================
  // Heartbeat checks

  // The flag shows for one cycle after the host sets it
  heartbeat_set_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    algo_wr_seen && reg_wdata[`HCC_HEARTBEAT_BIT] |=> host_heartbeat_flag)
    else $error("Heartbeat not raised");

  // Without a new write the flag falls back by itself
  heartbeat_auto_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    host_heartbeat_flag && !algo_wr_seen |=> !host_heartbeat_flag)
    else $error("Heartbeat did not self clear");

  // Writing zero to the heartbeat bit leaves the flag low
  beat_zero_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    algo_wr_seen && !reg_wdata[`HCC_HEARTBEAT_BIT]
    |=> !host_heartbeat_flag)
    else $error("Heartbeat raised by zero");

  // ============================================================
  // Speed checks

  // Register speed reaches the core two cycles after the write
  speed_value_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    speed_wr_seen && reg_wdata[`HCC_SRC_BIT] ##1 !speed_wr_seen
    |=> speed_command ==
      $past(reg_wdata[`HCC_SPEED_MSB:`HCC_SPEED_LSB], 2))
    else $error("Digital speed not applied");

  // With the pin source held, the pin value passes one cycle late
  source_pin_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    !speed_source_select ##1 !speed_source_select
    |-> speed_command == $past(pin_speed))
    else $error("Pin speed not routed");

  // The source select takes the written bit
  select_set_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    speed_wr_seen
    |=> speed_source_select == $past(reg_wdata[`HCC_SRC_BIT]))
    else $error("Source select not written");

  // The source select only moves on a write
  select_hold_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    !speed_wr_seen |=> $stable(speed_source_select))
    else $error("Source select moved");

  // First edge after reset: nothing active, pin source selected
  reset_zero_a: assert property (@(posedge clk)
    $past(sys_rst) && !sys_rst
    |-> !speed_source_select && speed_command == 15'h0000
      && !host_heartbeat_flag && !reg_rvalid
      && reg_rdata == 32'h00000000)
    else $error("Reset state not zero");

  // Status copy skips the cycle that still holds the reset value
  pin_status_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    !$past(sys_rst) |-> pin_speed_status == $past(pin_speed))
    else $error("Pin speed status stale");

  // ============================================================
  // Read checks

  // Every read strobe gets one answer, the next cycle
  rvalid_pulse_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    reg_rd |=> reg_rvalid)
    else $error("Read not answered");

  // No answer without a read
  rvalid_idle_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    !reg_rd |=> !reg_rvalid)
    else $error("Answer without read");

  // The command register and unmapped offsets read as zero
  other_read_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    reg_rd && reg_addr != `HCC_SPEED_CTL_OFS
    |=> reg_rdata == 32'h00000000)
    else $error("Read of non speed offset not zero");

  // Speed control reads back select, reserved bits read zero
  speed_read_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    speed_rd_seen && !speed_wr_seen
    |=> reg_rdata[`HCC_SRC_BIT] == speed_source_select
        && reg_rdata[31] == 1'b0 && reg_rdata[14:0] == 15'h0000)
    else $error("Speed control read wrong");

  // ============================================================
  // Coverage
  cov_store_c: cover property (@(posedge clk) store_config_trigger);
  cov_reject_c: cover property (@(posedge clk) store_key_reject);
  cov_digital_c: cover property (@(posedge clk) speed_source_select);
  cov_reload_c: cover property (@(posedge clk) reload_config_trigger);
  cov_beat_c: cover property (@(posedge clk) host_heartbeat_flag);
endmodule

/* File: bench/hcc_host_model.sv */
/*
  Host side of the register port: single writes and reads.
  Assumes the bench calls access from a process synced to clk.
*/
`timescale 1ns/1ps
module hcc_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
  end
  // ==========================================================
  // Access
  // Released lines invert so a stale word never looks valid
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule

/* File: bench/host_command_control_regs_bench.sv */
/*
  Self-checking bench for the host command register bank.
  Assumes the host model drives the register port on clk.
*/
`timescale 1ns/1ps
module host_command_control_regs_bench;
  localparam int CMD_BITS[5] = '{31, 30, 29, 28, 0};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, st, rl, cf, cr, rj, hb, sel;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, e8_shadow;
  logic [14:0] pin_speed = 15'h0000;
  logic [14:0] speed_command, pin_speed_status;
  logic [38:0] notes[$];
  int fail_count = 0;
  int checks = 0;

  always #5 clk = ~clk;

  hcc_host_model u_hcc_host_model (.clk(clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  hcc_regs_top u_hcc_regs_top (.clk(clk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pin_speed(pin_speed),
    .store_config_trigger(st), .reload_config_trigger(rl),
    .clear_faults_trigger(cf), .clear_retry_counts_trigger(cr),
    .store_key_reject(rj), .host_heartbeat_flag(hb),
    .speed_command(speed_command), .speed_source_select(sel),
    .pin_speed_status(pin_speed_status));

  // ==========================================================
  // Checking
  task automatic check(string name, logic [38:0] seen, logic [38:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Every pulse or read answer must match the oldest note
  always @(posedge clk) begin
    if (!sys_rst && (reg_rvalid | st | rl | cf | cr | rj | hb)) begin
      if (notes.size() == 0)
        check("stray", {reg_rvalid, st, rl, cf, cr, rj, hb, 32'h0}, 0);
      else
        check("event", {reg_rvalid, st, rl, cf, cr, rj, hb,
          reg_rvalid ? reg_rdata : 32'h0}, notes.pop_front());
    end
  end

  // ==========================================================
  // Driving
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ok;
    logic [38:0] e;
    ok = d[27:20] == `HCC_UNLOCK_KEY;
    e = {1'b0, d[31] & ok, d[30], d[29], d[28], d[31] & ~ok, d[0], 32'h0};
    if (a == 8'hE6 && e != 0) notes.push_back(e);
    if (a == 8'hE8) e8_shadow = d & 32'h7FFF8000;
    u_hcc_host_model.access(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    notes.push_back({1'b1, 6'h00, a == 8'hE8 ? e8_shadow : 32'h0});
    u_hcc_host_model.access(1'b0, a, 32'h0);
  endtask

  initial begin
    #200000;
    fail_count++;
    complete_run();
  end

  initial begin
    logic [31:0] d;
    void'($urandom(65));
    e8_shadow = 32'h0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'hE6);
    rd(8'hE8);
    @(negedge clk);
    check("select", {38'h0, sel}, 39'h0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) wr(8'hE6, 32'hA5 << 20 | 32'h1 << CMD_BITS[i]);
    wr(8'hE6, 32'h85A00000);
    wr(8'hE6, 32'h0);
    wr(8'hE6, 32'hFFFFFFFF);
    for (int i = 0; i < 16; i++) begin
      d = $urandom;
      if (i[0]) d[27:20] = 8'hA5;
      wr(8'hE6, d);
    end
    $display("test commands done");
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      @(posedge clk);
      pin_speed <= 15'($urandom);
      wr(8'hE8, d | 32'h8000);
      @(posedge clk);
      @(negedge clk);
      check("speed", {24'h0, speed_command}, {24'h0, d[30:16]});
      check("select", {38'h0, sel}, 39'h1);
      rd(8'hE8);
      wr(8'hE8, d & 32'hFFFF7FFF);
      repeat (3) @(negedge clk);
      check("pin", {24'h0, speed_command}, {24'h0, pin_speed});
      check("status", {24'h0, pin_speed_status}, {24'h0, pin_speed});
    end
    wr(8'hE8, 32'h7FFF8000);
    $display("test speed done");
    rd(8'hE9);
    rd(8'hE7);
    rd(8'hE8);
    $display("test unmapped done");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    e8_shadow = 32'h0;
    @(negedge clk);
    check("select", {38'h0, sel}, 39'h0);
    rd(8'hE8);
    $display("test rerun reset done");
    for (int k = 0; k < 20 && notes.size() != 0; k++) @(posedge clk);
    if (notes.size() != 0) check("drain", 39'h1, 39'h0);
    complete_run();
  end
endmodule
